/* hdl/mps_device.sv */
// module end: power on, orderly and emergency shutdown sequencing model
`timescale 1ns/10ps
module mps_device
    import mps_pkg::*;
#(
    // clock cycles in one second; a bench may shorten it
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and battery supply reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // control pins
    mps_if.device     pins,
    // user side
    input  wire logic shutdown_text_command,
    output logic      detach_request,
    output logic      powered
);
    // power state and timers
    mps_dev_state_e state_reg;
    logic [31:0]    tick_cnt_reg;
    logic           tick;
    logic [31:0]    st_tick_cnt_reg;
    logic           st_tick;
    logic [SEC_W-1:0] key_sec_reg;
    logic [SEC_W-1:0] emg_sec_reg;
    logic [SEC_W-1:0] st_sec_reg;
    // pin decodes and output registers
    logic           key_low;
    logic           key_seen_up_reg;
    logic           off_press;
    logic           emergency;
    logic           pm_reg;
    logic           rdy_reg;
    logic           detach_reg;

    // resolved pin levels and the requests decoded from them
    assign key_low   = ~pins.key_line_n;
    // emergency off acts in every state but off once held long enough
    assign emergency = (emg_sec_reg >= SEC_W'(EMERG_PRESS_S));
    // key shutdown counts only a fresh press, so a tied-low key cannot cycle power
    assign off_press = key_seen_up_reg && (key_sec_reg >= SEC_W'(OFF_PRESS_S));

    // free running one second tick for the hold timers; a press is
    // timed against it, so its phase never depends on the power state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || tick_cnt_reg == TICK_LEN - 1)
            tick_cnt_reg <= 32'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
    assign tick = (tick_cnt_reg == TICK_LEN - 1);

    // state tick restarted on each state change so boot, detach and
    // finalization last whole seconds and ready is never early
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || pm_next_state() || st_tick_cnt_reg == TICK_LEN - 1)
            st_tick_cnt_reg <= 32'h0;
        else
            st_tick_cnt_reg <= st_tick_cnt_reg + 32'h1;
    end
    assign st_tick = (st_tick_cnt_reg == TICK_LEN - 1);

    // key hold timer in whole seconds, saturating
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !key_low)
            key_sec_reg <= '0;
        else if (tick && key_sec_reg != '1)
            key_sec_reg <= key_sec_reg + 1'b1;
    end

    // emergency hold timer in whole seconds, saturating
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || pins.emergency_off_n)
            emg_sec_reg <= '0;
        else if (tick && emg_sec_reg != '1)
            emg_sec_reg <= emg_sec_reg + 1'b1;
    end

    // key must be seen released once the module is on before an off press counts
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || state_reg != MPS_DEV_ON)
            key_seen_up_reg <= 1'b0;
        else if (!key_low)
            key_seen_up_reg <= 1'b1;
    end

    // seconds spent in the current state
    // saturates so a stuck phase cannot wrap into a false exit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            st_sec_reg <= '0;
        else if (pm_next_state())
            st_sec_reg <= '0;
        else if (st_tick && st_sec_reg != '1)
            st_sec_reg <= st_sec_reg + 1'b1;
    end

    // state change strobe; restarts the state tick and seconds count
    function automatic logic pm_next_state();
        return next_state() != state_reg;
    endfunction

    // next power state
    // emergency off wins over every other request except a key press while off
    function automatic mps_dev_state_e next_state();
        mps_dev_state_e n;
        n = state_reg;
        if (emergency && state_reg != MPS_DEV_OFF)
            n = MPS_DEV_OFF;
        else
        begin
            case (state_reg)
                MPS_DEV_OFF:
                    // tied-low key starts after reset release as well
                    if (key_low)
                        n = MPS_DEV_BOOT;
                MPS_DEV_BOOT:
                    // boot cannot be cut short except by emergency off
                    if (st_sec_reg >= SEC_W'(BOOT_S))
                        n = MPS_DEV_ON;
                MPS_DEV_ON:
                    if (shutdown_text_command || off_press)
                        n = MPS_DEV_DETACH;
                MPS_DEV_DETACH:
                    if (st_sec_reg >= SEC_W'(DETACH_S))
                        n = MPS_DEV_FINAL;
                MPS_DEV_FINAL:
                    // finalization runs to its end unless emergency off cuts it short
                    if (st_sec_reg >= SEC_W'(FINAL_S))
                        n = MPS_DEV_OFF;
                default:
                    n = MPS_DEV_OFF;
            endcase
        end
        return n;
    endfunction

    // power state register; battery removal is the only reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            state_reg <= MPS_DEV_OFF;
        else
            state_reg <= next_state();
    end

    // power monitor: pads configured part way through boot, low once off
    // stays high through detach and finalization
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pm_reg <= 1'b0;
        else if (state_reg == MPS_DEV_BOOT && st_sec_reg >= SEC_W'(PADS_S))
            pm_reg <= 1'b1;
        else if (state_reg == MPS_DEV_OFF)
            pm_reg <= 1'b0;
    end

    // software ready only while fully operational
    // decoded from the next state so ready and ON change together
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rdy_reg <= 1'b0;
        else
            rdy_reg <= (next_state() == MPS_DEV_ON);
    end

    // detach request held for the whole detach phase
    // the emergency path skips it, as no network detach is sent
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            detach_reg <= 1'b0;
        else
            detach_reg <= (next_state() == MPS_DEV_DETACH);
    end

    // pin and user outputs; powered mirrors the monitor
    assign pins.power_monitor       = pm_reg;
    assign pins.software_ready_flag = rdy_reg;
    assign detach_request           = detach_reg;
    assign powered                  = pm_reg;
endmodule

/* hdl/mps_host.sv */
// host end: drives key and emergency lines, watches monitor and ready
`timescale 1ns/10ps
module mps_host
    import mps_pkg::*;
#(
    // clock cycles in one second; a bench may shorten it
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // control pins
    mps_if.host       pins,
    // user requests, one-cycle pulses
    input  wire logic power_on_req,
    input  wire logic power_off_req,
    input  wire logic emergency_req,
    // user status
    output logic      module_ready,
    output logic      module_off,
    output logic      busy
);
    mps_hst_state_e state_reg;
    logic [31:0]    tick_cnt_reg;
    logic           tick;
    logic [SEC_W-1:0] sec_reg;
    logic [SEC_W-1:0] press_len_reg;
    logic [1:0]     pm_sync_reg;
    logic [1:0]     rdy_sync_reg;
    logic           key_drive_reg;
    logic           emg_drive_reg;
    logic           press_active;

    // synchronise the module outputs
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pm_sync_reg  <= 2'h0;
            rdy_sync_reg <= 2'h0;
        end
        else
        begin
            pm_sync_reg  <= {pm_sync_reg[0], pins.power_monitor};
            rdy_sync_reg <= {rdy_sync_reg[0], pins.software_ready_flag};
        end
    end

    // timers run only while a line is pulled, so every press starts
    // from a fresh second, an emergency during the off wait included
    assign press_active = (state_reg == MPS_HST_PRESS) || (state_reg == MPS_HST_EMERG);

    // one second tick restarted at each press
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !press_active || tick_cnt_reg == TICK_LEN - 1)
            tick_cnt_reg <= 32'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
    assign tick = (tick_cnt_reg == TICK_LEN - 1);

    // press seconds counter
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !press_active)
            sec_reg <= '0;
        else if (tick)
            sec_reg <= sec_reg + 1'b1;
    end

    // sequencing; waits rely on the monitor and ready lines, never a delay
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_reg     <= MPS_HST_IDLE;
            press_len_reg <= '0;
        end
        else
        begin
            case (state_reg)
                MPS_HST_IDLE:
                    if (power_on_req && !pm_sync_reg[1])
                    begin
                        press_len_reg <= SEC_W'(ON_PRESS_S);
                        state_reg     <= MPS_HST_PRESS;
                    end
                MPS_HST_PRESS:
                    if (tick && sec_reg == press_len_reg - 1'b1)
                        state_reg <= (press_len_reg == SEC_W'(ON_PRESS_S))
                            ? MPS_HST_WAITUP : MPS_HST_WAITDN;
                MPS_HST_WAITUP:
                    if (rdy_sync_reg[1])
                        state_reg <= MPS_HST_READY;
                MPS_HST_READY:
                    if (emergency_req)
                        state_reg <= MPS_HST_EMERG;
                    else if (!pm_sync_reg[1])
                        state_reg <= MPS_HST_IDLE;
                    else if (power_off_req)
                    begin
                        press_len_reg <= SEC_W'(OFF_PRESS_S);
                        state_reg     <= MPS_HST_PRESS;
                    end
                MPS_HST_WAITDN:
                    if (emergency_req)
                        state_reg <= MPS_HST_EMERG;
                    else if (!pm_sync_reg[1])
                        state_reg <= MPS_HST_IDLE;
                MPS_HST_EMERG:
                    if (tick && sec_reg == SEC_W'(EMERG_PRESS_S - 1))
                        state_reg <= MPS_HST_IDLE;
                default:
                    state_reg <= MPS_HST_IDLE;
            endcase
        end
    end

    // pin drives: pull low only, otherwise release
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            key_drive_reg <= 1'b0;
            emg_drive_reg <= 1'b0;
        end
        else
        begin
            key_drive_reg <= (state_reg == MPS_HST_PRESS);
            emg_drive_reg <= (state_reg == MPS_HST_EMERG);
        end
    end

    // open drain: data fixed low, never driven high
    assign pins.key_out_n           = 1'b0;
    assign pins.key_oe              = key_drive_reg;
    assign pins.emergency_off_out_n = 1'b0;
    assign pins.emergency_off_oe    = emg_drive_reg;
    assign module_ready = (state_reg == MPS_HST_READY);
    assign module_off   = ~pm_sync_reg[1];
    assign busy         = (state_reg != MPS_HST_IDLE) && (state_reg != MPS_HST_READY);
endmodule

/* hdl/mps_if.sv */
// interface joining the host controller and the module control pins
`timescale 1ns/10ps
interface mps_if;
    logic key_out_n;
    logic key_oe;
    logic emergency_off_out_n;
    logic emergency_off_oe;
    logic power_monitor;
    logic software_ready_flag;
    logic key_line_n;
    logic emergency_off_n;

    // open drain lines with internal pull-up: low only while driven low
    assign key_line_n      = ~(key_oe & ~key_out_n);
    assign emergency_off_n = ~(emergency_off_oe & ~emergency_off_out_n);

    modport host
    (
        output key_out_n,
        output key_oe,
        output emergency_off_out_n,
        output emergency_off_oe,
        input  power_monitor,
        input  software_ready_flag
    );
    modport device
    (
        input  key_line_n,
        input  emergency_off_n,
        output power_monitor,
        output software_ready_flag
    );
endinterface

/* hdl/mps_pkg.sv */
// package of shared timing constants and states for the power sequencer
package mps_pkg;
    // clock rate and the one-second tick
    localparam longint unsigned CLK_HZ          = 64'd40000000;
    localparam int unsigned     TICK_CYCLES     = 32'(CLK_HZ);
    // bench second, short so a full run stays a few thousand cycles
    localparam int unsigned     SIM_TICK_CYCLES = 32'h10;
    // documented times in seconds
    localparam int unsigned     ON_PRESS_S      = 5;
    localparam int unsigned     OFF_PRESS_S     = 3;
    localparam int unsigned     EMERG_PRESS_S   = 2;
    localparam int unsigned     BOOT_S          = 25;
    localparam int unsigned     FINAL_S         = 16;
    localparam int unsigned     PADS_S          = 20;
    localparam int unsigned     DETACH_S        = 1;
    // second counter width
    localparam int unsigned     SEC_W           = 8;

    // device power states
    typedef enum logic [2:0]
    {
        MPS_DEV_OFF    = 3'b000,
        MPS_DEV_BOOT   = 3'b001,
        MPS_DEV_ON     = 3'b010,
        MPS_DEV_DETACH = 3'b011,
        MPS_DEV_FINAL  = 3'b100
    } mps_dev_state_e;

    // host sequencing states
    typedef enum logic [2:0]
    {
        MPS_HST_IDLE   = 3'b000,
        MPS_HST_PRESS  = 3'b001,
        MPS_HST_WAITUP = 3'b010,
        MPS_HST_READY  = 3'b011,
        MPS_HST_WAITDN = 3'b100,
        MPS_HST_EMERG  = 3'b101
    } mps_hst_state_e;
endpackage

/* verification/mps_properties.sv */
// concurrent checks on the control pins between host and module ends
`timescale 1ns/10ps
module mps_properties
    import mps_pkg::*;
#(
    // clock cycles in one second, as in both ends
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    // clock and battery reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host drive and resolved lines
    input wire logic key_out_n,
    input wire logic key_oe,
    input wire logic emergency_off_out_n,
    input wire logic emergency_off_oe,
    input wire logic key_line_n,
    input wire logic emergency_off_n,
    // module status
    input wire logic power_monitor,
    input wire logic software_ready_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    localparam int unsigned ON_CYC    = ON_PRESS_S * TICK_LEN;
    localparam int unsigned OFF_CYC   = OFF_PRESS_S * TICK_LEN;
    localparam int unsigned EMERG_CYC = EMERG_PRESS_S * TICK_LEN;
    localparam int unsigned BOOT_CYC  = BOOT_S * TICK_LEN;

    logic [31:0] key_cnt_reg;
    logic [31:0] emg_cnt_reg;
    logic [31:0] boot_cnt_reg;
    logic        key_q_reg;

    // press widths in cycles; a reset mid-press clears them
    always_ff @(posedge sys_clk)
    begin
        key_cnt_reg <= (!rst_n || !key_oe) ? 32'h0 : key_cnt_reg + 32'h1;
        emg_cnt_reg <= (!rst_n || !emergency_off_oe) ? 32'h0 : emg_cnt_reg + 32'h1;
    end

    // boot age restarts on a key press seen while off, saturates
    always_ff @(posedge sys_clk)
    begin
        key_q_reg <= key_line_n;
        if (!rst_n || (key_q_reg && !key_line_n && !power_monitor))
            boot_cnt_reg <= 32'h0;
        else if (boot_cnt_reg != 32'hffffffff)
            boot_cnt_reg <= boot_cnt_reg + 32'h1;
    end

    // finalization keeps the monitor up for a while after ready drops
    sequence s_final_hold;
        power_monitor [*8];
    endsequence

    // ready dropped with the emergency line high now and two cycles earlier
    sequence s_orderly_drop;
        $fell(software_ready_flag) && emergency_off_n && $past(emergency_off_n, 2);
    endsequence

    a_key_open_drain: assert property (!key_out_n)
        else $error("key driven high");
    a_emerg_open_drain: assert property (!emergency_off_out_n)
        else $error("emergency line driven high");
    a_key_press_width: assert property ($fell(key_oe) |->
        (key_cnt_reg == ON_CYC || key_cnt_reg == OFF_CYC))
        else $error("key press width wrong");
    a_emerg_press_width: assert property ($fell(emergency_off_oe) |->
        emg_cnt_reg == EMERG_CYC)
        else $error("emergency press width wrong");
    a_ready_after_pads: assert property (software_ready_flag |-> power_monitor)
        else $error("ready without monitor");
    a_boot_not_early: assert property ($rose(software_ready_flag) |->
        boot_cnt_reg >= BOOT_CYC)
        else $error("ready too early");
    a_host_waits_ready: assert property ($rose(key_oe) |->
        (!power_monitor || software_ready_flag))
        else $error("key pressed during boot");
    a_final_before_off: assert property (s_orderly_drop |-> s_final_hold)
        else $error("monitor dropped without finalization");
    a_emerg_forces_off: assert property ($fell(emergency_off_oe) |->
        ##[0:4] !power_monitor)
        else $error("emergency did not turn off");
endmodule

/* verification/tb.sv */
// self-checking bench joining host and module ends of the power sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb
    import mps_pkg::*;
;
    logic sys_clk               = 1'b0;
    logic rst_n                 = 1'b0;
    logic power_on_req          = 1'b0;
    logic power_off_req         = 1'b0;
    logic emergency_req         = 1'b0;
    logic shutdown_text_command = 1'b0;
    logic module_ready;
    logic module_off;
    logic busy;
    logic detach_request;
    logic powered;
    logic seen                  = 1'b0;
    int   cyc;
    int   total;
    int   bad_count             = 0;
    int   num_checks            = 0;

    mps_if pins();
    mps_device #(.TICK_LEN(SIM_TICK_CYCLES)) u_mps_device
        (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
        .shutdown_text_command(shutdown_text_command), .detach_request(detach_request),
        .powered(powered));
    mps_host #(.TICK_LEN(SIM_TICK_CYCLES)) u_mps_host
        (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
        .power_on_req(power_on_req), .power_off_req(power_off_req),
        .emergency_req(emergency_req), .module_ready(module_ready),
        .module_off(module_off), .busy(busy));
    mps_properties #(.TICK_LEN(SIM_TICK_CYCLES)) u_mps_properties
        (.sys_clk(sys_clk), .rst_n(rst_n),
        .key_out_n(pins.key_out_n), .key_oe(pins.key_oe),
        .emergency_off_out_n(pins.emergency_off_out_n),
        .emergency_off_oe(pins.emergency_off_oe), .key_line_n(pins.key_line_n),
        .emergency_off_n(pins.emergency_off_n), .power_monitor(pins.power_monitor),
        .software_ready_flag(pins.software_ready_flag));

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one-cycle request, raised and dropped at falling edges
    task automatic pulse(input int which);
        @(negedge sys_clk);
        case (which)
            0: power_on_req = 1'b1;
            1: power_off_req = 1'b1;
            2: emergency_req = 1'b1;
            default: shutdown_text_command = 1'b1;
        endcase
        @(negedge sys_clk);
        {power_on_req, power_off_req, emergency_req, shutdown_text_command} = 4'h0;
    endtask

    // bounded wait for a level; counts cycles and notes any detach
    task automatic wait_for(input int which, input logic val);
        logic cur;
        cyc = 0;
        cur = ~val;
        while (cur !== val && cyc < 60 * SIM_TICK_CYCLES)
        begin
            @(negedge sys_clk);
            cyc++;
            seen = seen | detach_request;
            case (which)
                0: cur = pins.power_monitor;
                1: cur = module_ready;
                2: cur = pins.key_line_n;
                default: cur = pins.emergency_off_n;
            endcase
        end
        `CHK(cur, val)
    endtask

    // full power on: key press, pads, then ready
    task automatic power_up();
        pulse(0);
        wait_for(2, 1'b0);
        `CHK(busy, 1'b1)
        wait_for(2, 1'b1);
        `CHK(cyc, ON_PRESS_S * SIM_TICK_CYCLES)
        total = cyc;
        wait_for(0, 1'b1);
        total += cyc;
        `CHK(pins.software_ready_flag, 1'b0)
        `CHK(powered, 1'b1)
        wait_for(1, 1'b1);
        total += cyc;
        `CHK(total >= BOOT_S * SIM_TICK_CYCLES, 1'b1)
        `CHK(pins.software_ready_flag, 1'b1)
        `CHK(busy, 1'b0)
        $display("test power on done");
    endtask

    // confirm the off state once the monitor has settled low
    task automatic off_state();
        repeat (4) @(negedge sys_clk);
        `CHK(module_off, 1'b1)
        `CHK(pins.software_ready_flag, 1'b0)
        `CHK(pins.power_monitor, 1'b0)
        `CHK(module_ready, 1'b0)
        `CHK(busy, 1'b0)
    endtask

    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        `CHK(pins.key_line_n, 1'b1)
        `CHK(pins.emergency_off_n, 1'b1)
        `CHK(powered, 1'b0)
        power_up();
        // an on request while running must leave the key alone
        pulse(0);
        repeat (3) @(negedge sys_clk);
        `CHK(pins.key_line_n, 1'b1)
        seen = 1'b0;
        pulse(3);
        wait_for(0, 1'b0);
        `CHK(seen, 1'b1)
        `CHK(cyc >= 15 * SIM_TICK_CYCLES, 1'b1)
        off_state();
        $display("test software off done");
        power_up();
        seen = 1'b0;
        pulse(1);
        wait_for(2, 1'b0);
        wait_for(2, 1'b1);
        `CHK(cyc, OFF_PRESS_S * SIM_TICK_CYCLES)
        `CHK(pins.power_monitor, 1'b1)
        wait_for(0, 1'b0);
        `CHK(seen, 1'b1)
        off_state();
        $display("test key off done");
        power_up();
        seen = 1'b0;
        pulse(2);
        wait_for(3, 1'b0);
        wait_for(3, 1'b1);
        `CHK(cyc, EMERG_PRESS_S * SIM_TICK_CYCLES)
        `CHK(seen, 1'b0)
        off_state();
        $display("test emergency off done");
        close_out();
    end

    // watchdog sized for about 250 s of module time
    initial
    begin
        #(25.0 * SIM_TICK_CYCLES * 250);
        `CHK(1'b0, 1'b1)
        close_out();
    end
endmodule
